/* File: inc/asc_consts.svh */
// Register indices, field positions, reset values and timing counts
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
`define ASC_IDX_RESULT 8'hF3
`define ASC_IDX_THR_FIRST 8'hF4
`define ASC_IDX_THR_LAST 8'hFB
`define ASC_IDX_CHSEL 8'hFC
`define ASC_IDX_CONV 8'hFD
`define ASC_IDX_IRQ 8'hFE
`define ASC_IDX_VECTOR 8'hFF
`define ASC_RST_CHSEL 8'h0F
`define ASC_RST_CONV 8'hA0
`define ASC_RST_IRQ 8'h07
`define ASC_RST_WORD_SEL 1'h1
`define ASC_BIT_RUN 0
`define ASC_BIT_REPEAT 1
`define ASC_BIT_ANALOG_ON 2
`define ASC_BIT_TIMER_TRIG 3
`define ASC_BIT_PIN_TRIG 4
`define ASC_BIT_DONE_FLAG 7
`define ASC_BIT_WINDOW_FLAG 6
`define ASC_BIT_DONE_MASK 5
`define ASC_BIT_WINDOW_MASK 4
`define ASC_LAST_CHANNEL 4'hF
`define ASC_SAMPLE_TICKS 5'h08
`define ASC_CONV_TICKS 5'h1C
`endif

/* File: inc/asc_pkg.sv */
// Types shared by the converter sequencer control
package asc_pkg;
	typedef enum logic [1:0] {
		ASC_IDLE = 2'h0,
		ASC_SAMPLE = 2'h1,
		ASC_CONVERT = 2'h3
	} asc_fsm_t;

	typedef struct packed {
		logic analog_en;
		logic conv_tick;
		logic sample_hold;
		logic [3:0] channel;
		logic result_valid;
	} asc_conv_out_t;

	typedef struct packed {
		logic req;
		logic [2:0] level;
		logic word_sel;
	} asc_irq_out_t;

	typedef struct packed {
		asc_fsm_t fsm;
		logic [7:0] chsel;
		logic [7:0] conv;
		logic [7:0] irq;
		logic [5:0] vector;
		logic [3:0] wres;
		logic [3:0][9:0] thr;
		logic [3:0] div_cnt;
		logic [4:0] tick_cnt;
		logic [3:0] channel;
		logic trig_s1;
		logic trig_s2;
		logic trig_s3;
		logic trig_lvl;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		asc_conv_out_t cout;
		asc_irq_out_t iout;
	} asc_state_t;
endpackage

/* File: core/asc_ctrl.sv */
// Converter sequencer control with APB register access
// Operation
// - Autoscan from first_channel up to channel 15
// - First channel 15 converts only channel 15
// - Control register write restarts sequence
// - Pair code N gives A=N-1, B=N
// - Crossing sets window_flag and window_result
// - Threshold low byte bits 5:0 read zero
// - Divider codes give divide by 2 to 16
// - Enabled pin edge starts a sequence
// - Enabled timer event starts a sequence
// - Trigger sources are ORed together
// - Trigger sets run_request; single mode clears it
// - analog_on low idles converter logic
// - Single mode: one sequence per start
// - Repeat mode: sequences follow continuously
// - run_request write 1 starts, 0 stops
// - done_flag set at sequence end; writable
// - window_flag software-clearable; write 1 requests
// - done_irq_mask gates done request
// - window_irq_mask gates window request
// - irq_level presented with requests
// - Above upper or below lower sets result
// - Thresholds 10 bits, high and low byte
// - Window request first; vector_word_sel 0/1
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_ctrl (
	input wire logic clk,
	input wire logic srst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trigger_pin,
	input wire logic timer_event,
	input wire logic [9:0] conv_data,
	output asc_pkg::asc_conv_out_t conv_out,
	output asc_pkg::asc_irq_out_t irq_out
);

	asc_pkg::asc_state_t s_reg;
	asc_pkg::asc_state_t s_next;

	// Threshold slot for an index: 0 A lower, 1 B lower, 2 A upper, 3 B upper
	function automatic logic [1:0] thr_slot(input logic [7:0] idx);
		logic [7:0] rel;
		rel = idx - `ASC_IDX_THR_FIRST;
		thr_slot = rel[2:1];
	endfunction

	function automatic logic is_thr(input logic [7:0] idx);
		is_thr = (idx >= `ASC_IDX_THR_FIRST) && (idx <= `ASC_IDX_THR_LAST);
	endfunction

	logic [7:0] idx;
	logic mapped;
	logic wr_ok;
	logic rd_phase;
	logic [31:0] rd_val;
	logic restart;
	logic tick;
	logic pin_edge;
	logic trig_hit;
	logic conv_end;
	logic seq_end;
	logic [3:0] ch_a;
	logic [3:0] ch_b;
	logic [3:0] wset;
	logic [9:0] thr_val;
	logic win_pend;
	logic done_pend;

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign conv_out = s_reg.cout;
	assign irq_out = s_reg.iout;

	always_comb begin
		s_next = s_reg;
		idx = paddr[9:2];
		mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
			&& (idx >= `ASC_IDX_RESULT);
		wr_ok = psel && penable && pwrite && s_reg.pready && mapped;
		rd_phase = psel && penable && !s_reg.pready;
		rd_val = 32'h0;
		thr_val = s_reg.thr[thr_slot(idx)];

		// Read multiplexer
		if (idx == `ASC_IDX_RESULT) begin
			rd_val[7:4] = s_reg.wres;
		end else if (is_thr(idx)) begin
			if (idx[0]) begin
				rd_val[7:6] = thr_val[1:0];
			end else begin
				rd_val[7:0] = thr_val[9:2];
			end
		end else if (idx == `ASC_IDX_CHSEL) begin
			rd_val[7:0] = s_reg.chsel;
		end else if (idx == `ASC_IDX_CONV) begin
			rd_val[7:0] = s_reg.conv;
		end else if (idx == `ASC_IDX_IRQ) begin
			rd_val[7:0] = s_reg.irq & 8'hF7;
		end else if (idx == `ASC_IDX_VECTOR) begin
			rd_val[7:0] = {s_reg.vector, s_reg.iout.word_sel, 1'b0};
		end

		// APB answer one cycle into the access phase
		s_next.pready = rd_phase;
		s_next.pslverr = rd_phase && !mapped;
		s_next.prdata = (rd_phase && !pwrite && mapped) ? rd_val : 32'h0;

		// Trigger pin synchroniser and stable level
		s_next.trig_s1 = trigger_pin;
		s_next.trig_s2 = s_reg.trig_s1;
		s_next.trig_s3 = s_reg.trig_s2;
		pin_edge = 1'b0;
		if (s_reg.trig_s2 == s_reg.trig_s3) begin
			s_next.trig_lvl = s_reg.trig_s3;
			pin_edge = s_reg.trig_lvl && !s_reg.trig_s3;
		end

		trig_hit = (pin_edge && s_reg.conv[`ASC_BIT_PIN_TRIG])
			|| (timer_event && s_reg.conv[`ASC_BIT_TIMER_TRIG]);

		// Register writes
		restart = 1'b0;
		if (wr_ok) begin
			if (idx == `ASC_IDX_RESULT) begin
				s_next.wres = pwdata[7:4];
			end else if (is_thr(idx)) begin
				// threshold write, low byte keeps 7:6
				if (idx[0]) begin
					s_next.thr[thr_slot(idx)][1:0] = pwdata[7:6];
				end else begin
					s_next.thr[thr_slot(idx)][9:2] = pwdata[7:0];
				end
			end else if (idx == `ASC_IDX_CHSEL) begin
				s_next.chsel = pwdata[7:0];
				restart = 1'b1;
			end else if (idx == `ASC_IDX_CONV) begin
				s_next.conv = pwdata[7:0];
				restart = 1'b1;
			end else if (idx == `ASC_IDX_IRQ) begin
				// software may set or clear flags
				s_next.irq = pwdata[7:0];
			end else if (idx == `ASC_IDX_VECTOR) begin
				s_next.vector = pwdata[7:2];
			end
		end

		tick = 1'b0;
		if (s_reg.conv[`ASC_BIT_ANALOG_ON] && s_reg.fsm != asc_pkg::ASC_IDLE) begin
			if (s_reg.div_cnt == {s_reg.conv[7:5], 1'b1}) begin
				s_next.div_cnt = 4'h0;
				tick = 1'b1;
			end else begin
				s_next.div_cnt = s_reg.div_cnt + 4'h1;
			end
		end else begin
			s_next.div_cnt = 4'h0;
		end

		// watched pair, A wraps to 15
		ch_b = s_reg.chsel[3:0];
		ch_a = ch_b - 4'h1;

		// Sequencer
		conv_end = 1'b0;
		seq_end = 1'b0;
		wset = 4'h0;
		if (tick) begin
			s_next.tick_cnt = s_reg.tick_cnt + 5'h1;
		end
		unique case (s_reg.fsm)
			asc_pkg::ASC_IDLE: begin
				s_next.tick_cnt = 5'h0;
				if (s_reg.conv[`ASC_BIT_RUN]
					&& s_reg.conv[`ASC_BIT_ANALOG_ON]) begin
					s_next.channel = s_reg.chsel[7:4];
					s_next.fsm = asc_pkg::ASC_SAMPLE;
				end
			end
			asc_pkg::ASC_SAMPLE: begin
				if (tick && s_reg.tick_cnt == `ASC_SAMPLE_TICKS - 5'h1) begin
					s_next.fsm = asc_pkg::ASC_CONVERT;
				end
			end
			asc_pkg::ASC_CONVERT: begin
				if (tick && s_reg.tick_cnt == `ASC_CONV_TICKS - 5'h1) begin
					conv_end = 1'b1;
					s_next.tick_cnt = 5'h0;
					if (s_reg.channel == `ASC_LAST_CHANNEL) begin
						seq_end = 1'b1;
						s_next.channel = s_reg.chsel[7:4];
						// repeat loops without a new start
						s_next.fsm = s_reg.conv[`ASC_BIT_REPEAT]
							? asc_pkg::ASC_SAMPLE : asc_pkg::ASC_IDLE;
					end else begin
						s_next.channel = s_reg.channel + 4'h1;
						s_next.fsm = asc_pkg::ASC_SAMPLE;
					end
				end
			end
			default: begin
				s_next.fsm = asc_pkg::ASC_IDLE;
			end
		endcase

		// window compare on the watched pair
		if (conv_end && s_reg.channel == ch_b) begin
			wset[3] = conv_data > s_reg.thr[3];
			wset[1] = conv_data < s_reg.thr[1];
		end
		if (conv_end && s_reg.channel == ch_a) begin
			wset[2] = conv_data > s_reg.thr[2];
			wset[0] = conv_data < s_reg.thr[0];
		end

		if (restart || !s_next.conv[`ASC_BIT_RUN]
			|| !s_next.conv[`ASC_BIT_ANALOG_ON]) begin
			s_next.fsm = asc_pkg::ASC_IDLE;
			s_next.tick_cnt = 5'h0;
			s_next.div_cnt = 4'h0;
			seq_end = 1'b0;
			conv_end = conv_end && !restart;
		end

		if (seq_end && !s_reg.conv[`ASC_BIT_REPEAT]) begin
			s_next.conv[`ASC_BIT_RUN] = 1'b0;
		end
		// trigger sets run_request, wins over clear
		if (trig_hit) begin
			s_next.conv[`ASC_BIT_RUN] = 1'b1;
		end

		// sticky result bits and window flag
		s_next.wres = s_next.wres | wset;
		if (wset != 4'h0) begin
			s_next.irq[`ASC_BIT_WINDOW_FLAG] = 1'b1;
		end
		if (seq_end) begin
			s_next.irq[`ASC_BIT_DONE_FLAG] = 1'b1;
		end
		s_next.irq[3] = 1'b0;

		win_pend = s_next.irq[`ASC_BIT_WINDOW_FLAG]
			&& s_next.irq[`ASC_BIT_WINDOW_MASK];
		done_pend = s_next.irq[`ASC_BIT_DONE_FLAG]
			&& s_next.irq[`ASC_BIT_DONE_MASK];
		s_next.iout.req = win_pend || done_pend;
		s_next.iout.level = s_next.irq[2:0];
		// window served first, done held pending
		if (win_pend) begin
			s_next.iout.word_sel = 1'b0;
		end else if (done_pend) begin
			s_next.iout.word_sel = 1'b1;
		end

		// Converter side outputs
		// analog enable follows analog_on
		s_next.cout.analog_en = s_next.conv[`ASC_BIT_ANALOG_ON];
		s_next.cout.conv_tick = tick;
		s_next.cout.sample_hold = s_next.fsm == asc_pkg::ASC_SAMPLE;
		s_next.cout.channel = s_next.channel;
		s_next.cout.result_valid = conv_end;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.fsm <= asc_pkg::ASC_IDLE;
			s_reg.chsel <= `ASC_RST_CHSEL;
			s_reg.conv <= `ASC_RST_CONV;
			s_reg.irq <= `ASC_RST_IRQ;
			s_reg.channel <= 4'h0;
			s_reg.trig_s1 <= 1'b1;
			s_reg.trig_s2 <= 1'b1;
			s_reg.trig_s3 <= 1'b1;
			s_reg.trig_lvl <= 1'b1;
			s_reg.iout.word_sel <= `ASC_RST_WORD_SEL;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

/* File: dv/asc_checker.sv */
// Port assertions for the sequencer control
`timescale 1ns/1ps
module asc_checker (
	input logic clk,
	input logic srst,
	input logic psel,
	input logic penable,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input asc_pkg::asc_conv_out_t conv_out
);
	logic sh_d;
	logic [5:0] tcnt;
	always_ff @(posedge clk) begin
		if (srst) begin
			sh_d <= 1'h0;
			tcnt <= 6'h00;
		end else begin
			sh_d <= conv_out.sample_hold;
			if (conv_out.sample_hold && !sh_d) tcnt <= 6'h00;
			else if (conv_out.conv_tick) tcnt <= tcnt + 6'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("late answer");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rdz; !pready |-> prdata == 32'h00000000; endproperty
	a_rdz: assert property (p_rdz) else $error("stray read data");
	property p_off;
		!conv_out.analog_en [*2] |->
			!conv_out.sample_hold && !conv_out.result_valid;
	endproperty
	a_off: assert property (p_off) else $error("active while off");
	property p_tick; conv_out.conv_tick |=> !conv_out.conv_tick; endproperty
	a_tick: assert property (p_tick) else $error("tick too fast");
	property p_conv;
		conv_out.result_valid |-> conv_out.conv_tick && tcnt == 6'h1B;
	endproperty
	a_conv: assert property (p_conv) else $error("tick count");
	property p_chan;
		conv_out.sample_hold && $past(conv_out.sample_hold) |->
			$stable(conv_out.channel);
	endproperty
	a_chan: assert property (p_chan) else $error("channel moved");
	c_res: cover property (conv_out.result_valid);
	c_err: cover property (pslverr);
	c_top: cover property (conv_out.sample_hold && conv_out.channel == 4'hF);
endmodule
bind asc_ctrl asc_checker chk_i (.clk(clk), .srst(srst), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .conv_out(conv_out));

/* File: dv/asc_partner.sv */
// Analog input mux and timer event source model
`timescale 1ns/1ps
module asc_partner (
	input logic clk,
	input logic fire,
	input asc_pkg::asc_conv_out_t cout,
	output logic [9:0] conv_data,
	output logic timer_event = 1'h0
);
	logic [3:0] held = 4'h0;
	always @(posedge clk) begin
		timer_event <= fire;
		if (cout.sample_hold) held <= cout.channel;
	end
	// Level per channel, scrambled when powered down
	assign conv_data = cout.analog_en ? {held, 6'h05} : ~{held, 6'h05};
endmodule

/* File: dv/asc_tb.sv */
// Self-checking bench for the sequencer control
`timescale 1ns/1ps
module testbench;
	logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pin = 1'h1, fire = 1'h0, pready, pslverr, tev;
	logic sh_d = 1'h0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic [9:0] cdata;
	logic [7:0] rd;
	logic [3:0] chq[$];
	int cyc = 0;
	int tq[$];
	int fq[$];
	asc_pkg::asc_conv_out_t cout;
	asc_pkg::asc_irq_out_t iout;
	int err_total = 0, checked = 0;
	always #4 clk = ~clk;
	asc_ctrl dut (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_pin(pin), .timer_event(tev), .conv_data(cdata),
		.conv_out(cout), .irq_out(iout));
	asc_partner mdl (.clk(clk), .fire(fire), .cout(cout),
		.conv_data(cdata), .timer_event(tev));
	always @(posedge clk) begin
		sh_d <= cout.sample_hold;
		cyc <= cyc + 1;
		if (cout.sample_hold && !sh_d) begin
			chq.push_back(cout.channel);
			tq.push_back(cyc);
		end
		if (!cout.sample_hold && sh_d) fq.push_back(cyc);
	end
	task automatic end_sim();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tmo();
		err_total++;
		$display("[FAIL] %0t timeout", $time);
		end_sim();
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) tmo();
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'h0, 12'h3F4, 8'h00);
			n++;
		end while (rd[0] !== 1'h0 && n < 300);
		if (rd[0] !== 1'h0) tmo();
	endtask
	task automatic wait_rises(input int k);
		int n;
		for (n = 0; n < 3000 && chq.size() < k; n++) @(posedge clk);
		if (chq.size() < k) tmo();
	endtask
	task automatic s_reset();
		apb(1'h0, 12'h3F0, 8'h00);
		chk(rd, 8'h0F);
		apb(1'h0, 12'h3F4, 8'h00);
		chk(rd, 8'hA0);
		apb(1'h0, 12'h3F8, 8'h00);
		chk(rd, 8'h07);
		apb(1'h0, 12'h000, 8'h00);
		chk({7'h00, er}, 8'h01);
		apb(1'h1, 12'h3EC, 8'hFF);
		apb(1'h0, 12'h3EC, 8'h00);
		chk(rd, 8'hC0);
	endtask
	task automatic s_scan();
		chq.delete();
		apb(1'h1, 12'h3F0, 8'hC1);
		apb(1'h1, 12'h3F4, 8'h05);
		wait_idle();
		chk(8'(chq.size()), 8'h04);
		for (int i = 0; i < 4; i++) chk({4'h0, chq[i]}, 8'(12 + i));
		apb(1'h0, 12'h3F8, 8'h00);
		chk(rd, 8'h87);
		apb(1'h1, 12'h3F8, 8'h07);
		apb(1'h1, 12'h3D0, 8'hFF);
		apb(1'h0, 12'h3D0, 8'h00);
		chk(rd, 8'hFF);
		chq.delete();
		apb(1'h1, 12'h3F0, 8'hF0);
		apb(1'h1, 12'h3F4, 8'h05);
		wait_idle();
		chk({4'h0, chq[0]}, 8'h0F);
		chk(8'(chq.size()), 8'h01);
		apb(1'h0, 12'h3CC, 8'h00);
		chk(rd & 8'hF0, 8'h50);
		apb(1'h0, 12'h3F8, 8'h00);
		chk(rd, 8'hC7);
	endtask
	task automatic s_trig();
		chq.delete();
		apb(1'h1, 12'h3F4, 8'h14);
		pin <= 1'h0;
		repeat (4) @(posedge clk);
		pin <= 1'h1;
		wait_idle();
		chk(8'(chq.size()), 8'h01);
		apb(1'h1, 12'h3F4, 8'h0C);
		fire <= 1'h1;
		@(posedge clk);
		fire <= 1'h0;
		wait_idle();
		chk(8'(chq.size()), 8'h02);
		apb(1'h1, 12'h3F4, 8'h04);
		pin <= 1'h0;
		fire <= 1'h1;
		@(posedge clk);
		fire <= 1'h0;
		repeat (4) @(posedge clk);
		pin <= 1'h1;
		repeat (60) @(posedge clk);
		chk(8'(chq.size()), 8'h02);
	endtask
	task automatic s_repeat();
		logic [3:0] e [6];
		int sz;
		e = '{4'hD, 4'hE, 4'hD, 4'hE, 4'hF, 4'hD};
		chq.delete();
		apb(1'h1, 12'h3F0, 8'hD0);
		apb(1'h1, 12'h3F4, 8'h07);
		wait_rises(2);
		repeat (20) @(posedge clk);
		apb(1'h1, 12'h3F0, 8'hD0);
		wait_rises(6);
		apb(1'h1, 12'h3F4, 8'h04);
		sz = chq.size();
		repeat (100) @(posedge clk);
		chk(8'(chq.size()), 8'(sz));
		for (int i = 0; i < 6; i++) chk({4'h0, chq[i]}, {4'h0, e[i]});
	endtask
	task automatic s_irq();
		logic [7:0] w [7];
		logic [7:0] x [7];
		w = '{8'h45, 8'h55, 8'h03, 8'hA2, 8'h82, 8'hF1, 8'hB1};
		x = '{8'h0A, 8'h1A, 8'h06, 8'h15, 8'h04, 8'h12, 8'h13};
		for (int i = 0; i < 7; i++) begin
			apb(1'h1, 12'h3F8, w[i]);
			repeat (2) @(posedge clk);
			chk({3'h0, iout.req, iout.level, iout.req & iout.word_sel}, x[i]);
		end
		apb(1'h1, 12'h3FC, 8'hFF);
		apb(1'h0, 12'h3FC, 8'h00);
		chk(rd, 8'hFE);
	endtask
	task automatic s_div();
		int d;
		chq.delete();
		tq.delete();
		fq.delete();
		apb(1'h1, 12'h3F0, 8'hF0);
		apb(1'h1, 12'h3F4, 8'h67);
		wait_rises(2);
		apb(1'h1, 12'h3F4, 8'h04);
		d = tq[1] - tq[0];
		chk(8'(d), 8'hE0);
		chk(8'(d >> 8), 8'h00);
		chk(8'(fq[0] - tq[0]), 8'h40);
		chk({4'h0, chq[1]}, 8'h0F);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		s_reset();
		s_scan();
		s_trig();
		s_repeat();
		s_irq();
		s_div();
		end_sim();
	end
endmodule
